// ### rtl/afs_pkg.sv
package afs_pkg;

   // Converted analogue samples
   localparam int unsigned ADC_W       = 12;
   localparam int unsigned PCT_W       = 7;

   // Demand window and tracking limit, percent of supply
   localparam logic [PCT_W-1:0] WIN_LO_PCT  = 7'h0f;
   localparam logic [PCT_W-1:0] WIN_HI_PCT  = 7'h55;
   localparam logic [PCT_W-1:0] TRACK_PCT   = 7'h0c;
   localparam logic [PCT_W-1:0] FULL_PCT    = 7'h64;

   // Supply thresholds in millivolts, supply sample is in millivolts / 16
   localparam int unsigned OVER_MV     = 36000;
   localparam int unsigned UNDER_MV    = 8500;
   localparam int unsigned SUP_LSB_MV  = 16;
   localparam logic [ADC_W-1:0] OVER_CODE  = ADC_W'(OVER_MV / SUP_LSB_MV);
   localparam logic [ADC_W-1:0] UNDER_CODE = ADC_W'((UNDER_MV + SUP_LSB_MV - 1) / SUP_LSB_MV);

   // Timing
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned QUAL_MS     = 250;
   localparam int unsigned HOLD_MS     = 100;
   localparam int unsigned QUAL_CYC    = (CLK_HZ / 1000) * QUAL_MS;
   localparam int unsigned HOLD_CYC    = (CLK_HZ / 1000) * HOLD_MS;
   localparam int unsigned CNT_W       = 23;

endpackage : afs_pkg

// ### rtl/afs_sup_if.sv
`timescale 1ns/1ns
interface afs_sup_if;
   import afs_pkg::*;
   logic [ADC_W-1:0] supply;
   logic             clk_ok;
   logic             over_v;
   logic             under_v;
   logic             kill;
   modport ctrl (output supply, output clk_ok, input over_v, input under_v, input kill);
   modport mon  (input supply, input clk_ok, output over_v, output under_v, output kill);
endinterface : afs_sup_if

// ### rtl/afs_supply_mon.sv
`timescale 1ns/1ns
module afs_supply_mon
   import afs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Supervision signals
   afs_sup_if.mon   sup
);
   typedef struct packed {
      logic over_v;
      logic under_v;
      logic kill;
   } afs_mon_t;

   afs_mon_t st_reg;
   afs_mon_t st_next;

   always_comb begin
      st_next         = st_reg;
      st_next.over_v  = sup.supply > OVER_CODE;
      st_next.under_v = sup.supply < UNDER_CODE;
      st_next.kill    = st_next.over_v || st_next.under_v || !sup.clk_ok;
      if (srst) begin
         st_next = '{over_v: 1'b0, under_v: 1'b0, kill: 1'b1};
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   assign sup.over_v  = st_reg.over_v;
   assign sup.under_v = st_reg.under_v;
   assign sup.kill    = st_reg.kill;

   AST_OVER_KILL: assert property (@(posedge clk) disable iff (srst)
      (sup.supply > OVER_CODE) |=> sup.kill && sup.over_v)
      else $error("overvoltage did not disable pilots");
   AST_UNDER_KILL: assert property (@(posedge clk) disable iff (srst)
      (sup.supply < UNDER_CODE) |=> sup.kill && sup.under_v)
      else $error("undervoltage did not disable pilots");
   AST_CLK_KILL: assert property (@(posedge clk) disable iff (srst)
      !sup.clk_ok |=> sup.kill)
      else $error("clock failure did not disable pilots");

endmodule : afs_supply_mon

// ### rtl/afs_top.sv
`timescale 1ns/1ns
module afs_top
   import afs_pkg::*;
#(
   parameter int unsigned QUAL_CYCLES = QUAL_CYC,
   parameter int unsigned HOLD_CYCLES = HOLD_CYC
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Analogue samples
   input  wire logic [ADC_W-1:0] supply,
   input  wire logic [ADC_W-1:0] demand,
   input  wire logic [ADC_W-1:0] spool_pos,
   // Transducer and clock status
   input  wire logic             xdcr_open,
   input  wire logic             xdcr_short,
   input  wire logic             clk_ok,
   // Outputs
   output logic                  alarm,
   output logic                  bridge_en,
   output logic                  active_err
);
   typedef enum logic [1:0] {AFS_IDLE, AFS_QUAL, AFS_ALARM} afs_state_t;

   typedef struct packed {
      afs_state_t       state;
      logic [CNT_W-1:0] qual_cnt;
      logic [CNT_W-1:0] hold_cnt;
      logic             err;
      logic             alarm;
      logic             bridge_en;
   } afs_top_t;

   afs_top_t st_reg;
   afs_top_t st_next;

   afs_sup_if sup ();

   assign sup.supply = supply;
   assign sup.clk_ok = clk_ok;

   afs_supply_mon u_mon (
      .clk  (clk),
      .srst (srst),
      .sup  (sup)
   );

   // Scale a value by a percentage, result in hundredths of sample units
   function automatic logic [ADC_W+PCT_W-1:0] afs_pct(
      input logic [ADC_W-1:0] val,
      input logic [PCT_W-1:0] pct
   );
      afs_pct = (ADC_W+PCT_W)'(val * pct);
   endfunction : afs_pct

   // Mid-scale of the supply is spool neutral; signed offset from it
   logic [ADC_W-1:0]      half_sup;
   logic signed [ADC_W:0] dem_off;
   logic signed [ADC_W:0] pos_off;
   logic [ADC_W-1:0]      dem_mag;
   logic [ADC_W-1:0]      pos_mag;
   logic                  same_side;
   logic                  win_err;
   logic                  track_err;
   logic                  raw_err;
   logic [ADC_W+PCT_W-1:0] dem_scaled;
   logic [ADC_W+PCT_W-1:0] over_scaled;

   always_comb begin
      half_sup   = supply >> 1;
      dem_off    = $signed({1'b0, demand}) - $signed({1'b0, half_sup});
      pos_off    = $signed({1'b0, spool_pos}) - $signed({1'b0, half_sup});
      dem_mag    = dem_off[ADC_W] ? ADC_W'(-dem_off) : dem_off[ADC_W-1:0];
      pos_mag    = pos_off[ADC_W] ? ADC_W'(-pos_off) : pos_off[ADC_W-1:0];
      same_side  = dem_off[ADC_W] == pos_off[ADC_W];
      dem_scaled = (ADC_W+PCT_W)'(demand) * (ADC_W+PCT_W)'(FULL_PCT);
      win_err    = (dem_scaled < afs_pct(supply, WIN_LO_PCT))
                || (dem_scaled > afs_pct(supply, WIN_HI_PCT));
      // Overshoot measured as percent of full supply span
      over_scaled = (ADC_W+PCT_W)'(pos_mag - dem_mag) * (ADC_W+PCT_W)'(FULL_PCT);
      track_err  = (!same_side && pos_mag != '0 && dem_mag != '0)
                     ? ((ADC_W+PCT_W)'(pos_mag + dem_mag) * (ADC_W+PCT_W)'(FULL_PCT)
                        > afs_pct(supply, TRACK_PCT))
                     : ((pos_mag > dem_mag)
                        && (over_scaled > afs_pct(supply, TRACK_PCT)));
      raw_err    = win_err || xdcr_open || xdcr_short || track_err;
   end

   always_comb begin
      st_next           = st_reg;
      st_next.err       = raw_err;
      st_next.bridge_en = !sup.kill;
      unique case (st_reg.state)
         AFS_IDLE: begin
            st_next.qual_cnt = '0;
            if (st_reg.err) begin
               st_next.state    = AFS_QUAL;
               st_next.qual_cnt = CNT_W'(1);
            end
         end
         AFS_QUAL: begin
            if (!st_reg.err) begin
               st_next.state    = AFS_IDLE;
               st_next.qual_cnt = '0;
            end else if (st_reg.qual_cnt >= CNT_W'(QUAL_CYCLES - 1)) begin
               st_next.state    = AFS_ALARM;
               st_next.alarm    = 1'b1;
               st_next.hold_cnt = '0;
            end else begin
               st_next.qual_cnt = st_reg.qual_cnt + CNT_W'(1);
            end
         end
         AFS_ALARM: begin
            if (st_reg.hold_cnt < CNT_W'(HOLD_CYCLES - 1)) begin
               st_next.hold_cnt = st_reg.hold_cnt + CNT_W'(1);
            end else if (!st_reg.err) begin
               st_next.state    = AFS_IDLE;
               st_next.alarm    = 1'b0;
               st_next.qual_cnt = '0;
            end
         end
         default: begin
            st_next.state = AFS_IDLE;
            st_next.alarm = 1'b0;
         end
      endcase
      if (srst) begin
         st_next = '{state: AFS_IDLE, qual_cnt: '0, hold_cnt: '0,
                     err: 1'b0, alarm: 1'b0, bridge_en: 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      st_reg <= st_next;
   end

   // Alarm comes from the fault path only; supervision is not an input to it
   assign alarm      = st_reg.alarm;
   assign bridge_en  = st_reg.bridge_en;
   assign active_err = st_reg.err;

   // Qualification and hold cycle counters for checks
   logic [CNT_W-1:0] err_run_reg;
   always_ff @(posedge clk) begin
      if (srst || !st_reg.err) begin
         err_run_reg <= '0;
      end else if (err_run_reg != '1) begin
         err_run_reg <= err_run_reg + CNT_W'(1);
      end
   end

   logic [CNT_W-1:0] alarm_run_reg;
   always_ff @(posedge clk) begin
      if (srst || !st_reg.alarm) begin
         alarm_run_reg <= '0;
      end else if (alarm_run_reg != '1) begin
         alarm_run_reg <= alarm_run_reg + CNT_W'(1);
      end
   end

   AST_WIN_ERR: assert property (@(posedge clk) disable iff (srst)
      ((ADC_W+PCT_W)'(demand) * FULL_PCT < (ADC_W+PCT_W)'(supply) * WIN_LO_PCT) |=> active_err)
      else $error("demand below window not flagged");
   AST_XDCR_ERR: assert property (@(posedge clk) disable iff (srst)
      (xdcr_open || xdcr_short) |=> active_err)
      else $error("transducer fault not flagged");
   AST_IN_CONTROL: assert property (@(posedge clk) disable iff (srst)
      (same_side && pos_mag <= dem_mag && !win_err && !xdcr_open && !xdcr_short)
      |=> !active_err)
      else $error("in control position flagged as error");
   AST_NO_EARLY: assert property (@(posedge clk) disable iff (srst)
      $rose(alarm) |-> $past(err_run_reg) >= CNT_W'(QUAL_CYCLES - 1))
      else $error("alarm raised before qualification delay");
   AST_RAISE: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_QUAL && st_reg.err
       && st_reg.qual_cnt == CNT_W'(QUAL_CYCLES - 1)) |=> alarm)
      else $error("alarm not raised after qualification");
   AST_BRIDGE_ON: assert property (@(posedge clk) disable iff (srst)
      (alarm && !sup.kill) |=> bridge_en || sup.kill)
      else $error("bridge disabled by alarm");
   AST_MIN_HOLD: assert property (@(posedge clk) disable iff (srst)
      $fell(alarm) |-> $past(alarm_run_reg) >= CNT_W'(HOLD_CYCLES - 1))
      else $error("alarm shorter than minimum hold");
   AST_DROP: assert property (@(posedge clk) disable iff (srst)
      (alarm && !st_reg.err && st_reg.hold_cnt >= CNT_W'(HOLD_CYCLES - 1)) |=> !alarm)
      else $error("alarm latched after error cleared");
   AST_RESTART: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_QUAL && !st_reg.err) |=> st_reg.qual_cnt == '0 && !alarm)
      else $error("qualification timer not restarted");
   AST_SUP_NO_ALARM: assert property (@(posedge clk) disable iff (srst)
      (!alarm && st_reg.state == AFS_IDLE && !st_reg.err) |=> !alarm)
      else $error("alarm raised outside fault path");

   // Window, transducer, tracking, qualification and hold detail
   AST_WIN_HI: assert property (@(posedge clk) disable iff (srst)
      ((ADC_W+PCT_W)'(demand) * FULL_PCT > (ADC_W+PCT_W)'(supply) * WIN_HI_PCT) |=> active_err)
      else $error("demand above window not flagged");

   AST_XDCR_SHORT: assert property (@(posedge clk) disable iff (srst)
      xdcr_short |=> active_err)
      else $error("shorted transducer not flagged");

   AST_TRACK_OVER: assert property (@(posedge clk) disable iff (srst)
      (same_side && pos_mag > dem_mag && (ADC_W+PCT_W)'(pos_mag - dem_mag) * FULL_PCT
       > (ADC_W+PCT_W)'(supply) * TRACK_PCT) |=> active_err)
      else $error("overshoot beyond demand not flagged");

   AST_OPP_SIDE: assert property (@(posedge clk) disable iff (srst)
      (!same_side && pos_mag != '0 && dem_mag != '0 && (ADC_W+PCT_W)'(pos_mag + dem_mag)
       * FULL_PCT > (ADC_W+PCT_W)'(supply) * TRACK_PCT) |=> active_err)
      else $error("spool across neutral not flagged");

   AST_CLEAN_NO_ERR: assert property (@(posedge clk) disable iff (srst)
      (!win_err && !xdcr_open && !xdcr_short && !track_err) |=> !active_err)
      else $error("error held without a cause");

   AST_ENTER_QUAL: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_IDLE && st_reg.err) |=> st_reg.state == AFS_QUAL
      && st_reg.qual_cnt == CNT_W'(1))
      else $error("error did not start qualification");

   AST_QUAL_STEP: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_QUAL && st_reg.err && st_reg.qual_cnt < CNT_W'(QUAL_CYCLES - 1))
      |=> st_reg.qual_cnt == $past(st_reg.qual_cnt) + CNT_W'(1))
      else $error("qualification timer did not advance");

   AST_QUAL_NO_ALARM: assert property (@(posedge clk) disable iff (srst)
      st_reg.state == AFS_QUAL |-> !alarm)
      else $error("alarm active during qualification");

   AST_QUAL_BOUND: assert property (@(posedge clk) disable iff (srst)
      st_reg.qual_cnt <= CNT_W'(QUAL_CYCLES - 1))
      else $error("qualification timer out of range");

   AST_ALARM_STATE: assert property (@(posedge clk) disable iff (srst)
      alarm == (st_reg.state == AFS_ALARM))
      else $error("alarm output disagrees with state");

   AST_STATE_LEGAL: assert property (@(posedge clk) disable iff (srst)
      st_reg.state inside {AFS_IDLE, AFS_QUAL, AFS_ALARM})
      else $error("illegal supervisor state");

   AST_RISE_FROM_QUAL: assert property (@(posedge clk) disable iff (srst)
      $rose(alarm) |-> $past(st_reg.state) == AFS_QUAL)
      else $error("alarm raised outside qualification");

   AST_ALARM_KEEP_ERR: assert property (@(posedge clk) disable iff (srst)
      (alarm && st_reg.err) |=> alarm)
      else $error("alarm dropped while error present");

   AST_HOLD_STAY: assert property (@(posedge clk) disable iff (srst)
      (alarm && st_reg.hold_cnt < CNT_W'(HOLD_CYCLES - 1)) |=> alarm)
      else $error("alarm dropped inside minimum hold");

   AST_HOLD_STEP: assert property (@(posedge clk) disable iff (srst)
      (alarm && st_reg.hold_cnt < CNT_W'(HOLD_CYCLES - 1))
      |=> st_reg.hold_cnt == $past(st_reg.hold_cnt) + CNT_W'(1))
      else $error("hold timer did not advance");

   AST_HOLD_BOUND: assert property (@(posedge clk) disable iff (srst)
      st_reg.hold_cnt <= CNT_W'(HOLD_CYCLES - 1))
      else $error("hold timer out of range");

   AST_FALL_NO_ERR: assert property (@(posedge clk) disable iff (srst)
      $fell(alarm) |-> !$past(st_reg.err))
      else $error("alarm dropped with error present");

   AST_IDLE_STAY: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_IDLE && !st_reg.err) |=> st_reg.state == AFS_IDLE)
      else $error("supervisor left idle without error");

   AST_RESTART_IDLE: assert property (@(posedge clk) disable iff (srst)
      (st_reg.state == AFS_QUAL && !st_reg.err) |=> st_reg.state == AFS_IDLE)
      else $error("cleared error did not abort qualification");

   AST_KILL_KEEP_ALARM: assert property (@(posedge clk) disable iff (srst)
      (alarm && st_reg.err && sup.kill) |=> alarm)
      else $error("supervision changed the alarm");

   // Pilot supervision seen at the bridge output
   AST_BRIDGE_OVER: assert property (@(posedge clk) disable iff (srst)
      (supply > OVER_CODE) |-> ##2 !bridge_en)
      else $error("bridge on during overvoltage");

   AST_BRIDGE_UNDER: assert property (@(posedge clk) disable iff (srst)
      (supply < UNDER_CODE) |-> ##2 !bridge_en)
      else $error("bridge on during undervoltage");

   AST_BRIDGE_CLK: assert property (@(posedge clk) disable iff (srst)
      !clk_ok |-> ##2 !bridge_en)
      else $error("bridge on during clock failure");

   AST_BRIDGE_UP: assert property (@(posedge clk) disable iff (srst)
      (supply <= OVER_CODE && supply >= UNDER_CODE && clk_ok) |-> ##2 bridge_en)
      else $error("bridge off with healthy supply and clock");

endmodule : afs_top

// ### dv/afs_watchdog_model.sv
`timescale 1ns/1ns
module afs_watchdog_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Observed signals
   input  wire logic       alarm,
   input  wire logic       motion_fault,
   // Valve power and alarm tally
   output logic            dump_pwr,
   output logic [7:0]      alarm_cnt
);
   logic alarm_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         dump_pwr  <= 1'b1;
         alarm_cnt <= 8'h00;
         alarm_reg <= 1'b0;
      end else begin
         alarm_reg <= alarm;
         if (motion_fault) begin
            dump_pwr <= 1'b0;
         end
         if (alarm && !alarm_reg) begin
            alarm_cnt <= alarm_cnt + 8'h01;
         end
      end
   end
endmodule : afs_watchdog_model

// ### dv/afs_top_tb_top.sv
`timescale 1ns/1ns
module afs_top_tb_top;
   import afs_pkg::*;
   localparam int QC = 20;
   localparam int HC = 8;
   logic             clk, srst, xdcr_open, xdcr_short, clk_ok, motion_fault;
   logic [ADC_W-1:0] supply, demand, spool_pos;
   logic             alarm, bridge_en, active_err, dump_pwr;
   logic [7:0]       alarm_cnt;
   int               fail_count = 0;
   int               tests_run = 0;
   int               n, h;

   afs_top #(.QUAL_CYCLES(QC), .HOLD_CYCLES(HC)) dut (.clk(clk), .srst(srst),
      .supply(supply), .demand(demand), .spool_pos(spool_pos), .xdcr_open(xdcr_open),
      .xdcr_short(xdcr_short), .clk_ok(clk_ok), .alarm(alarm), .bridge_en(bridge_en),
      .active_err(active_err));
   afs_watchdog_model wd (.clk(clk), .srst(srst), .alarm(alarm),
      .motion_fault(motion_fault), .dump_pwr(dump_pwr), .alarm_cnt(alarm_cnt));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task chk(input string name, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", name, exp, got);
      end
   endtask : chk

   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task wait_rise(output int c);
      c = 0;
      while (alarm !== 1'b1 && c < QC + 10) begin
         tick(1);
         c++;
      end
      if (alarm !== 1'b1) begin
         fail_count++;
         $display("BAD alarm rise expected 1 seen %b", alarm);
         stop_test();
      end
   endtask : wait_rise

   task err_case(input logic [11:0] d, input logic [11:0] p, input logic exp);
      @(posedge clk);
      demand <= d;
      spool_pos <= p;
      tick(3);
      chk("active_err", exp, active_err);
      chk("alarm early", 1'b0, alarm);
      @(posedge clk);
      demand <= 12'h2ee;
      spool_pos <= 12'h2ee;
      tick(3);
   endtask : err_case

   task t_window;
      err_case(12'h0e1, 12'h2ee, 1'b0);
      err_case(12'h0e0, 12'h2ee, 1'b1);
      err_case(12'h4fb, 12'h2ee, 1'b0);
      err_case(12'h4fc, 12'h2ee, 1'b1);
      err_case(12'h3e8, 12'h49c, 1'b0);
      err_case(12'h3e8, 12'h49d, 1'b1);
      err_case(12'h1f4, 12'h13f, 1'b1);
      err_case(12'h3e8, 12'h320, 1'b0);
   endtask : t_window

   task t_xdcr;
      @(posedge clk);
      xdcr_open <= 1'b1;
      tick(3);
      chk("open err", 1'b1, active_err);
      xdcr_open <= 1'b0;
      xdcr_short <= 1'b1;
      tick(3);
      chk("short err", 1'b1, active_err);
      xdcr_short <= 1'b0;
      tick(4);
   endtask : t_xdcr

   task t_qual;
      @(posedge clk);
      xdcr_short <= 1'b1;
      wait_rise(n);
      chk("alarm delay", 1'b1, n >= QC && n <= QC + 4);
      chk("alarm on", 1'b1, alarm);
      tick(2 * HC);
      chk("bridge run", 1'b1, bridge_en);
      chk("alarm held", 1'b1, alarm);
      xdcr_short <= 1'b0;
      tick(4);
      chk("alarm off", 1'b0, alarm);
   endtask : t_qual

   task t_hold;
      @(posedge clk);
      xdcr_open <= 1'b1;
      wait_rise(n);
      xdcr_open <= 1'b0;
      h = 0;
      while (alarm === 1'b1 && h < HC + 10) begin
         tick(1);
         h++;
      end
      chk("hold time", 1'b1, h >= HC - 1 && h <= HC + 3);
   endtask : t_hold

   task t_abort;
      @(posedge clk);
      xdcr_open <= 1'b1;
      tick(QC - 4);
      xdcr_open <= 1'b0;
      tick(4);
      chk("abort alarm", 1'b0, alarm);
      xdcr_open <= 1'b1;
      wait_rise(n);
      chk("timer restart", 1'b1, n >= QC);
      xdcr_open <= 1'b0;
      tick(HC + 4);
   endtask : t_abort

   task sup_case(input logic [11:0] s, input logic ok, input logic exp);
      @(posedge clk);
      supply <= s;
      demand <= s >> 1;
      spool_pos <= s >> 1;
      clk_ok <= ok;
      tick(QC + 6);
      chk("bridge_en", exp, bridge_en);
      chk("no alarm", 1'b0, alarm);
      chk("no err", 1'b0, active_err);
   endtask : sup_case

   task t_supply;
      sup_case(12'h8cb, 1'b1, 1'b0);
      sup_case(12'h8ca, 1'b1, 1'b1);
      sup_case(12'h213, 1'b1, 1'b0);
      sup_case(12'h214, 1'b1, 1'b1);
      sup_case(12'h5dc, 1'b0, 1'b0);
      sup_case(12'h5dc, 1'b1, 1'b1);
   endtask : t_supply

   task t_watch;
      chk("alarm count", 1'b1, alarm_cnt === 8'h03);
      @(posedge clk);
      motion_fault <= 1'b1;
      tick(2);
      chk("dump power", 1'b0, dump_pwr);
   endtask : t_watch

   initial begin
      srst = 1'b1;
      supply = 12'h5dc;
      demand = 12'h2ee;
      spool_pos = 12'h2ee;
      xdcr_open = 1'b0;
      xdcr_short = 1'b0;
      clk_ok = 1'b1;
      motion_fault = 1'b0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      tick(3);
      chk("bridge up", 1'b1, bridge_en);
      t_window();
      t_xdcr();
      t_qual();
      t_hold();
      t_abort();
      t_supply();
      t_watch();
      stop_test();
   end
endmodule : afs_top_tb_top
